// file: hdl/iftw_defs.svh
// How it works
// - Recommended multiword DMA cycle word never below the minimum DMA cycle time.
// - Any supported timing word sets the group-valid flag; unsupported ones read zero.
// - PIO mode 3+ reports no-flow cycle time, not below the flow-controlled one.
// - Flow-controlled PIO word holds the fastest supported PIO mode cycle time.
// - With the group flag set, unsupported PIO cycle words read zero.
// - Second and third supported words carry bit 14 set, bit 15 clear.
// - First supported word: bits 3,12,13,14 one; 2,4,7,8,9,10 zero.
// - SMART, security, write cache, look-ahead support bits only when implemented.
// - Second supported word: bit 2 set, bits 0,1,4 clear, bit 3 shows APM.
// - Reserved bits of second and third supported words read zero.
// - Third enabled word: bit 14 one, bit 15 zero, lower bits zero.
// - SMART enable is host-writable and survives a power cycle.
// - First enabled word shows security, write cache and look-ahead enables.
// - First enabled word mirrors the fixed bits of the first supported word.
// - Second enabled word: bit 3 APM enabled, bit 2 CFA, bits 0,1,4 zero.
// - At most one DMA mode selected; UDMA and MDMA selections exclude each other.
// - Ultra DMA word reads zero outside True IDE or without UDMA support.
// - Ultra DMA word bits 8..14 select modes 0..6; bits 7, 15 reserved.
// - Ultra DMA support bits 0..6 are cumulative.
// - Minimum multiword DMA cycle time is not reported in any word; it serves only as reference for the recommended word.
`ifndef IFTW_DEFS_SVH
`define IFTW_DEFS_SVH

// Identify word numbers
`define IFTW_W_MDMA_REC     8'h42
`define IFTW_W_PIO_NOFLOW   8'h43
`define IFTW_W_PIO_FLOW     8'h44
`define IFTW_W_SUP1         8'h52
`define IFTW_W_SUP2         8'h53
`define IFTW_W_SUP3         8'h54
`define IFTW_W_EN1          8'h55
`define IFTW_W_EN2          8'h56
`define IFTW_W_EN3          8'h57
`define IFTW_W_UDMA         8'h58

// Fixed bit patterns of the feature words
`define IFTW_FIX1_ONES      16'h7008
`define IFTW_FIX1_MASK      16'h779c
`define IFTW_VALID_MARK     16'h4000
`define IFTW_CFA_BIT        2
`define IFTW_APM_BIT        3
`define IFTW_SMART_BIT      0
`define IFTW_SEC_BIT        1
`define IFTW_WCACHE_BIT     5
`define IFTW_LOOK_BIT       6
`define IFTW_UDMA_SEL_LSB   8

// Default cycle times in ns
`define IFTW_MDMA_MIN_NS    16'h0078
`define IFTW_MDMA_REC_NS    16'h0078
`define IFTW_PIO_NOFLOW_NS  16'h0078
`define IFTW_PIO_FLOW_NS    16'h0078

`endif

// file: hdl/iftw_pkg.sv
package iftw_pkg;
	typedef enum logic [2:0] {
		IFTW_OP_UDMA,
		IFTW_OP_MDMA,
		IFTW_OP_SMART,
		IFTW_OP_SECURITY,
		IFTW_OP_WCACHE,
		IFTW_OP_LOOKAHEAD,
		IFTW_OP_APM
	} iftw_op_t;

	// Feature or mode change taken from a completed host command
	typedef struct packed {
		logic      valid;
		iftw_op_t  op;
		logic      enable;
		logic [2:0] mode;
	} iftw_cmd_t;
endpackage

// file: hdl/iftw_identify_words.sv
`timescale 1ns/10ps
`default_nettype none
`include "iftw_defs.svh"

module iftw_identify_words #(
	parameter logic [15:0] MDMA_MIN_NS   = `IFTW_MDMA_MIN_NS,
	parameter logic [15:0] MDMA_REC_NS   = `IFTW_MDMA_REC_NS,
	parameter logic [15:0] PIO_NOFLOW_NS = `IFTW_PIO_NOFLOW_NS,
	parameter logic [15:0] PIO_FLOW_NS   = `IFTW_PIO_FLOW_NS,
	parameter int          MDMA_MAX_MODE = 2,
	parameter bit          PIO3_SUP      = 1'b1,
	parameter int          UDMA_MAX_MODE = 4,
	parameter bit          SMART_SUP     = 1'b1,
	parameter bit          SEC_SUP       = 1'b0,
	parameter bit          WCACHE_SUP    = 1'b1,
	parameter bit          LOOK_SUP      = 1'b0,
	parameter bit          APM_SUP       = 1'b0
) (
	input  wire logic              mclk_in,
	input  wire logic              rst_n_in,
	input  wire logic              true_ide_in,
	input  wire logic              smart_nv_in,
	input  wire iftw_pkg::iftw_cmd_t cmd_in,
	input  wire logic              rd_req_in,
	input  wire logic [7:0]        word_index_in,
	output logic [15:0]            rd_data_out,
	output logic                   rd_valid_out,
	output logic                   timing_valid_out,
	output logic                   smart_nv_out,
	output logic [2:0]             mdma_sel_out
);
	import iftw_pkg::*;

	// ********************************
	// Parameter checks
	// ********************************
	if (UDMA_MAX_MODE < -1 || UDMA_MAX_MODE > 6) begin : g_bad_udma
		$error("UDMA_MAX_MODE must be -1..6");
	end
	if (MDMA_MAX_MODE < -1 || MDMA_MAX_MODE > 2) begin : g_bad_mdma
		$error("MDMA_MAX_MODE must be -1..2");
	end
	if (MDMA_MAX_MODE >= 1 && MDMA_REC_NS < MDMA_MIN_NS) begin : g_bad_rec
		$error("Recommended DMA cycle below minimum");
	end
	if (PIO3_SUP && PIO_NOFLOW_NS < PIO_FLOW_NS) begin : g_bad_pio
		$error("No-flow PIO cycle below flow-controlled cycle");
	end

	localparam bit MDMA_WORDS_SUP = (MDMA_MAX_MODE >= 1);
	localparam bit UDMA_SUP       = (UDMA_MAX_MODE >= 0);

	// ********************************
	// Helpers
	// ********************************
	function automatic logic [6:0] cum_mask(input int max_mode);
		logic [6:0] m;
		m = 7'h00;
		for (int i = 0; i < 7; i++)
			if (i <= max_mode)
				m[i] = 1'b1;
		return m;
	endfunction

	function automatic logic [2:0] onehot3(input logic [2:0] n);
		logic [2:0] r;
		r = 3'h0;
		r[n[1:0]] = 1'b1;
		return r;
	endfunction

	localparam logic [6:0] UDMA_SUP_MASK = cum_mask(UDMA_MAX_MODE);
	localparam logic [2:0] MDMA_SUP_MASK = 3'(cum_mask(MDMA_MAX_MODE));

	// ********************************
	// True IDE strap synchroniser
	// ********************************
	logic ide_s1;
	logic ide_s2;
	logic ide_s3;
	logic true_ide;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ide_s1 <= 1'b0;
			ide_s2 <= 1'b0;
			ide_s3 <= 1'b0;
		end else begin
			ide_s1 <= true_ide_in;
			ide_s2 <= ide_s1;
			ide_s3 <= ide_s2;
		end
	end

	// Level changes only once two stages agree
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			true_ide <= 1'b0;
		else if (ide_s2 == ide_s3)
			true_ide <= ide_s3;
	end

	// ********************************
	// DMA mode selection
	// ********************************
	logic [6:0] udma_sel;
	logic [2:0] mdma_sel;
	logic       take_udma;
	logic       take_mdma;

	assign take_udma = cmd_in.valid && cmd_in.op == IFTW_OP_UDMA && cmd_in.mode <= 3'd6
		&& UDMA_SUP_MASK[cmd_in.mode];
	assign take_mdma = cmd_in.valid && cmd_in.op == IFTW_OP_MDMA && cmd_in.mode <= 3'd2
		&& MDMA_SUP_MASK[cmd_in.mode[1:0]];

	// Unsupported modes are ignored, so the old selection stands
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			udma_sel <= 7'h00;
			mdma_sel <= 3'h0;
		end else if (take_udma) begin
			udma_sel <= 7'(1) << cmd_in.mode;
			mdma_sel <= 3'h0;
		end else if (take_mdma) begin
			mdma_sel <= onehot3(cmd_in.mode);
			udma_sel <= 7'h00;
		end
	end

	// ********************************
	// Feature enables
	// ********************************
	logic smart_en;
	logic smart_loaded;
	logic sec_en;
	logic wcache_en;
	logic look_en;
	logic apm_en;

	function automatic logic hit(input iftw_cmd_t c, input iftw_op_t o, input bit sup);
		return c.valid && c.op == o && sup;
	endfunction

	// Stored copy restored once after reset so the setting survives power loss
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			smart_en     <= 1'b0;
			smart_loaded <= 1'b0;
		end else if (!smart_loaded) begin
			smart_en     <= smart_nv_in;
			smart_loaded <= 1'b1;
		end else if (hit(cmd_in, IFTW_OP_SMART, SMART_SUP)) begin
			smart_en <= cmd_in.enable;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sec_en    <= 1'b0;
			wcache_en <= 1'b0;
			look_en   <= 1'b0;
			apm_en    <= 1'b0;
		end else begin
			if (hit(cmd_in, IFTW_OP_SECURITY, SEC_SUP))
				sec_en <= cmd_in.enable;
			if (hit(cmd_in, IFTW_OP_WCACHE, WCACHE_SUP))
				wcache_en <= cmd_in.enable;
			if (hit(cmd_in, IFTW_OP_LOOKAHEAD, LOOK_SUP))
				look_en <= cmd_in.enable;
			if (hit(cmd_in, IFTW_OP_APM, APM_SUP))
				apm_en <= cmd_in.enable;
		end
	end

	// ********************************
	// Word assembly
	// ********************************
	logic [15:0] sup1;
	logic [15:0] en1;
	logic [15:0] udma_word;
	logic [15:0] next_rd_data;

	always_comb begin
		sup1 = `IFTW_FIX1_ONES;
		sup1[`IFTW_SMART_BIT]  = SMART_SUP;
		sup1[`IFTW_SEC_BIT]    = SEC_SUP;
		sup1[`IFTW_WCACHE_BIT] = WCACHE_SUP;
		sup1[`IFTW_LOOK_BIT]   = LOOK_SUP;
		en1 = `IFTW_FIX1_ONES;
		en1[`IFTW_SMART_BIT]  = smart_en;
		en1[`IFTW_SEC_BIT]    = sec_en;
		en1[`IFTW_WCACHE_BIT] = wcache_en;
		en1[`IFTW_LOOK_BIT]   = look_en;
	end

	// Zero outside True IDE even if a mode was picked in another interface mode
	always_comb begin
		udma_word = 16'h0000;
		if (true_ide && UDMA_SUP)
			udma_word = {1'b0, udma_sel, 1'b0, UDMA_SUP_MASK};
	end

	always_comb begin
		if (word_index_in == `IFTW_W_MDMA_REC)
			next_rd_data = MDMA_WORDS_SUP ? MDMA_REC_NS : 16'h0000;
		else if (word_index_in == `IFTW_W_PIO_NOFLOW)
			next_rd_data = PIO3_SUP ? PIO_NOFLOW_NS : 16'h0000;
		else if (word_index_in == `IFTW_W_PIO_FLOW)
			next_rd_data = PIO3_SUP ? PIO_FLOW_NS : 16'h0000;
		else if (word_index_in == `IFTW_W_SUP1)
			next_rd_data = sup1;
		else if (word_index_in == `IFTW_W_SUP2)
			next_rd_data = `IFTW_VALID_MARK | (16'(1) << `IFTW_CFA_BIT)
				| (16'(APM_SUP) << `IFTW_APM_BIT);
		else if (word_index_in == `IFTW_W_SUP3)
			next_rd_data = `IFTW_VALID_MARK;
		else if (word_index_in == `IFTW_W_EN1)
			next_rd_data = en1;
		else if (word_index_in == `IFTW_W_EN2)
			next_rd_data = (16'(1) << `IFTW_CFA_BIT) | (16'(apm_en) << `IFTW_APM_BIT);
		else if (word_index_in == `IFTW_W_EN3)
			next_rd_data = `IFTW_VALID_MARK;
		else if (word_index_in == `IFTW_W_UDMA)
			next_rd_data = udma_word;
		else
			next_rd_data = 16'h0000;
	end

	// ********************************
	// Read port and status outputs
	// ********************************
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out  <= 16'h0000;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_req_in;
			if (rd_req_in)
				rd_data_out <= next_rd_data;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timing_valid_out <= 1'b0;
			smart_nv_out     <= 1'b0;
			mdma_sel_out     <= 3'h0;
		end else begin
			timing_valid_out <= MDMA_WORDS_SUP || PIO3_SUP;
			smart_nv_out     <= smart_en;
			mdma_sel_out     <= mdma_sel;
		end
	end

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_read_of(logic [7:0] w);
		rd_req_in && word_index_in == w;
	endsequence

	sequence s_udma_pick;
		take_udma;
	endsequence

	a_rec_over_min: assert property (s_read_of(`IFTW_W_MDMA_REC) |=>
		rd_data_out == 16'h0000 || rd_data_out >= MDMA_MIN_NS)
		else $error("Recommended DMA cycle below minimum");

	a_group_flag: assert property (s_read_of(`IFTW_W_PIO_FLOW) |=>
		rd_data_out == 16'h0000 || timing_valid_out)
		else $error("Timing word without group flag");

	a_pio_order: assert property (s_read_of(`IFTW_W_PIO_NOFLOW) ##1 !rd_req_in
		##1 s_read_of(`IFTW_W_PIO_FLOW)
		|=> rd_data_out <= $past(rd_data_out) || $past(rd_data_out) == 16'h0000)
		else $error("No-flow PIO cycle below flow cycle");

	a_sup1_fixed: assert property (s_read_of(`IFTW_W_SUP1) |=>
		(rd_data_out & `IFTW_FIX1_MASK) == `IFTW_FIX1_ONES)
		else $error("Fixed bits of first supported word wrong");

	a_sup_valid: assert property (s_read_of(`IFTW_W_SUP3) or s_read_of(`IFTW_W_SUP2) |=>
		rd_data_out[15:14] == 2'b01 && rd_data_out[13:4] == 10'h000)
		else $error("Supported word validity mark wrong");

	a_en3_word: assert property (s_read_of(`IFTW_W_EN3) |=>
		rd_data_out == `IFTW_VALID_MARK)
		else $error("Third enabled word wrong");

	a_dma_onehot: assert property ($onehot0({udma_sel, mdma_sel}))
		else $error("More than one DMA mode selected");

	a_udma_clears: assert property (s_udma_pick |=> mdma_sel == 3'h0 ##1 mdma_sel_out == 3'h0)
		else $error("UDMA pick left an MDMA selection");

	a_udma_ide_gate: assert property (rd_req_in && !true_ide
		&& word_index_in == `IFTW_W_UDMA |=> rd_data_out == 16'h0000)
		else $error("Ultra DMA word set outside True IDE");

	a_udma_layout: assert property (s_read_of(`IFTW_W_UDMA) |=>
		!rd_data_out[15] && !rd_data_out[7]
		&& ((rd_data_out[6:0] & (rd_data_out[6:0] + 7'h01)) == 7'h00))
		else $error("Ultra DMA word layout wrong");

	a_smart_update: assert property (smart_loaded && cmd_in.valid && cmd_in.op == IFTW_OP_SMART
		&& SMART_SUP |=> smart_en == $past(cmd_in.enable) ##1 smart_nv_out == smart_en)
		else $error("SMART enable not updated");

	// ********************************
	// Read port and feature word checks
	// ********************************
	a_rd_answer: assert property (rd_req_in |=> rd_valid_out)
		else $error("Read request not answered");

	a_rd_pulse: assert property (!rd_req_in |=> !rd_valid_out)
		else $error("Read valid without request");

	a_rd_hold: assert property (!rd_req_in |=> $stable(rd_data_out))
		else $error("Read data moved without request");

	a_timing_flag: assert property (rd_valid_out |->
		timing_valid_out == (MDMA_WORDS_SUP || PIO3_SUP))
		else $error("Timing group flag wrong");

	a_rec_present: assert property (s_read_of(`IFTW_W_MDMA_REC) |=>
		rd_data_out != 16'h0000 || !MDMA_WORDS_SUP)
		else $error("Recommended DMA cycle word missing");

	a_pio_present: assert property (s_read_of(`IFTW_W_PIO_NOFLOW)
		or s_read_of(`IFTW_W_PIO_FLOW) |=> rd_data_out != 16'h0000 || !PIO3_SUP)
		else $error("PIO cycle word missing");

	a_sup1_optional: assert property (s_read_of(`IFTW_W_SUP1) |=>
		(!rd_data_out[`IFTW_SMART_BIT] || SMART_SUP)
		&& (!rd_data_out[`IFTW_SEC_BIT] || SEC_SUP)
		&& (!rd_data_out[`IFTW_WCACHE_BIT] || WCACHE_SUP)
		&& (!rd_data_out[`IFTW_LOOK_BIT] || LOOK_SUP))
		else $error("Optional support bit without feature");

	a_sup2_bits: assert property (s_read_of(`IFTW_W_SUP2) |=>
		rd_data_out[`IFTW_CFA_BIT] && rd_data_out[1:0] == 2'b00 && !rd_data_out[4]
		&& rd_data_out[`IFTW_APM_BIT] == APM_SUP)
		else $error("Second supported word wrong");

	a_sup3_resv: assert property (s_read_of(`IFTW_W_SUP3) |=>
		rd_data_out[13:0] == 14'h0000)
		else $error("Third supported word reserved bits set");

	a_en1_fixed: assert property (s_read_of(`IFTW_W_EN1) |=>
		(rd_data_out & `IFTW_FIX1_MASK) == `IFTW_FIX1_ONES)
		else $error("Fixed bits of first enabled word wrong");

	a_en1_needs_sup: assert property (s_read_of(`IFTW_W_EN1) |=>
		(!rd_data_out[`IFTW_SEC_BIT] || SEC_SUP)
		&& (!rd_data_out[`IFTW_WCACHE_BIT] || WCACHE_SUP)
		&& (!rd_data_out[`IFTW_LOOK_BIT] || LOOK_SUP))
		else $error("Feature enabled without support");

	a_en2_bits: assert property (s_read_of(`IFTW_W_EN2) |=>
		rd_data_out[`IFTW_CFA_BIT] && rd_data_out[1:0] == 2'b00 && rd_data_out[15:4] == 12'h000
		&& (!rd_data_out[`IFTW_APM_BIT] || APM_SUP))
		else $error("Second enabled word wrong");

	a_udma_sel_one: assert property (s_read_of(`IFTW_W_UDMA) |=>
		$onehot0(rd_data_out[14:8]))
		else $error("Several Ultra DMA modes shown selected");

	a_mdma_clears: assert property (take_mdma |=> udma_sel == 7'h00 && $onehot(mdma_sel))
		else $error("MDMA pick left a UDMA selection");

	a_smart_restore: assert property (!smart_loaded |=> smart_loaded
		&& smart_en == $past(smart_nv_in))
		else $error("SMART enable not restored after reset");
endmodule

`default_nettype wire

// file: bench/iftw_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module iftw_host_model (
	input  wire logic           mclk_in,
	output var iftw_pkg::iftw_cmd_t cmd_out,
	output logic                rd_req_out,
	output logic [7:0]          word_index_out,
	input  wire logic [15:0]    rd_data_in,
	input  wire logic           rd_valid_in
);
	import iftw_pkg::*;
	// ****************
	// Host side drivers
	// ****************
	initial begin
		cmd_out = '0;
		rd_req_out = 1'b0;
		word_index_out = 8'h00;
	end
	// Answer lands on the edge that samples the request and is read half a cycle later
	task automatic rd_word(input logic [7:0] idx, output logic [15:0] data, output logic vld);
		@(negedge mclk_in);
		rd_req_out = 1'b1;
		word_index_out = idx;
		@(posedge mclk_in);
		@(negedge mclk_in);
		rd_req_out = 1'b0;
		// Released index shows the inverse, never a stale match
		word_index_out = ~idx;
		vld = rd_valid_in;
		data = rd_data_in;
	endtask
	task automatic send_cmd(input iftw_op_t op, input logic en, input logic [2:0] mode);
		@(negedge mclk_in);
		cmd_out = '{valid: 1'b1, op: op, enable: en, mode: mode};
		@(posedge mclk_in);
		@(negedge mclk_in);
		cmd_out = '{valid: 1'b0, op: iftw_op_t'(~op), enable: ~en, mode: ~mode};
	endtask
	// Host only asks whether an indication exists, never relies on content
	function automatic logic feat_ok(input logic [15:0] w);
		return (w !== 16'h0000) && (w !== 16'hFFFF);
	endfunction
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	import iftw_pkg::*;
	logic        mclk_in;
	logic        rst_n_in;
	logic        true_ide_in;
	logic        smart_nv_in;
	iftw_cmd_t   cmd;
	logic        rd_req;
	logic [7:0]  idx;
	logic [15:0] rd_data;
	logic        rd_valid;
	logic        timing_valid;
	logic        smart_nv;
	logic [2:0]  mdma_sel;
	logic [15:0] d;
	logic        v;
	int          fail_count = 0;
	int          n_tests = 0;
	int          cycles = 0;
	// ****************
	// Design and host
	// ****************
	iftw_identify_words #(.MDMA_REC_NS(16'h0096), .PIO_FLOW_NS(16'h0064), .SEC_SUP(1'b1),
		.LOOK_SUP(1'b1), .APM_SUP(1'b1)) i_iftw_identify_words (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .true_ide_in(true_ide_in),
		.smart_nv_in(smart_nv_in), .cmd_in(cmd), .rd_req_in(rd_req),
		.word_index_in(idx), .rd_data_out(rd_data), .rd_valid_out(rd_valid),
		.timing_valid_out(timing_valid), .smart_nv_out(smart_nv), .mdma_sel_out(mdma_sel));
	iftw_host_model i_iftw_host_model (.mclk_in(mclk_in), .cmd_out(cmd), .rd_req_out(rd_req),
		.word_index_out(idx), .rd_data_in(rd_data), .rd_valid_in(rd_valid));
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	// ****************
	// Checking
	// ****************
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd_chk(input logic [7:0] w, input logic [15:0] exp);
		i_iftw_host_model.rd_word(w, d, v);
		check("rd_valid_out", {15'h0000, v}, 16'h0001);
		check($sformatf("word %0d", w), d, exp);
	endtask
	// Far longer than the sequence needs
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 2000) begin
			fail_count++;
			test_done;
		end
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		rst_n_in = 1'b0;
		true_ide_in = 1'b1;
		smart_nv_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		rst_n_in = 1'b1;
		// Mode input passes a synchroniser first
		repeat (6) @(negedge mclk_in);
		check("timing_valid_out", {15'h0000, timing_valid}, 16'h0001);
		rd_chk(8'h42, 16'h0096);
		rd_chk(8'h43, 16'h0078);
		rd_chk(8'h44, 16'h0064);
		rd_chk(8'h45, 16'h0000);
		rd_chk(8'h52, 16'h706B);
		rd_chk(8'h53, 16'h400C);
		rd_chk(8'h54, 16'h4000);
		rd_chk(8'h55, 16'h7009);
		rd_chk(8'h56, 16'h0004);
		rd_chk(8'h57, 16'h4000);
		check("indication", {15'h0000, i_iftw_host_model.feat_ok(d)}, 16'h0001);
		rd_chk(8'h58, 16'h001F);
		i_iftw_host_model.send_cmd(IFTW_OP_SECURITY, 1'b1, 3'h0);
		i_iftw_host_model.send_cmd(IFTW_OP_WCACHE, 1'b1, 3'h0);
		i_iftw_host_model.send_cmd(IFTW_OP_LOOKAHEAD, 1'b1, 3'h0);
		i_iftw_host_model.send_cmd(IFTW_OP_APM, 1'b1, 3'h0);
		i_iftw_host_model.send_cmd(IFTW_OP_SMART, 1'b0, 3'h0);
		rd_chk(8'h55, 16'h706A);
		rd_chk(8'h56, 16'h000C);
		check("smart_nv_out", {15'h0000, smart_nv}, 16'h0000);
		i_iftw_host_model.send_cmd(IFTW_OP_UDMA, 1'b1, 3'h2);
		rd_chk(8'h58, 16'h041F);
		i_iftw_host_model.send_cmd(IFTW_OP_MDMA, 1'b1, 3'h1);
		rd_chk(8'h58, 16'h001F);
		check("mdma_sel_out", {13'h0000, mdma_sel}, 16'h0002);
		i_iftw_host_model.send_cmd(IFTW_OP_UDMA, 1'b1, 3'h4);
		rd_chk(8'h58, 16'h101F);
		check("mdma_sel_out", {13'h0000, mdma_sel}, 16'h0000);
		// Mode above the supported maximum is ignored
		i_iftw_host_model.send_cmd(IFTW_OP_UDMA, 1'b1, 3'h5);
		rd_chk(8'h58, 16'h101F);
		i_iftw_host_model.send_cmd(IFTW_OP_UDMA, 1'b1, 3'h0);
		rd_chk(8'h58, 16'h011F);
		true_ide_in = 1'b0;
		repeat (6) @(negedge mclk_in);
		rd_chk(8'h58, 16'h0000);
		// Power cycle: SMART enable comes back from the store
		smart_nv_in = 1'b0;
		rst_n_in = 1'b0;
		repeat (2) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		rd_chk(8'h55, 16'h7008);
		check("mdma_sel_out", {13'h0000, mdma_sel}, 16'h0000);
		test_done;
	end
endmodule
`default_nettype wire
